/* design/hlss_defs.vh */
// Constants for the head load and seek sequencer.
// Assumes a 10 MHz hclk; every count below derives from it.
`ifndef HLSS_DEFS_VH
`define HLSS_DEFS_VH

// Clock period in ns
`define HLSS_CLK_NS 100
// Settle delay after brake, in ns
`define HLSS_SETTLE_NS 1300000
// Load and unload timeout, in ms
`define HLSS_LOAD_TMO_MS 1250
// Seek timeout, in ms
`define HLSS_SEEK_TMO_MS 90
// Derived cycle counts (least time rounds up)
`define HLSS_SETTLE_CYC ((`HLSS_SETTLE_NS + `HLSS_CLK_NS - 1) / `HLSS_CLK_NS)
`define HLSS_LOAD_TMO_CYC ((`HLSS_LOAD_TMO_MS * 1000000) / `HLSS_CLK_NS)
`define HLSS_SEEK_TMO_CYC ((`HLSS_SEEK_TMO_MS * 1000000) / `HLSS_CLK_NS)

// Register byte offsets
`define HLSS_REG_CTRL 4'h0
`define HLSS_REG_STATUS 4'h4
`define HLSS_REG_CYL 4'h8
// Control register fields
`define HLSS_CTRL_RUN 0
`define HLSS_CTRL_FCLR 1
`define HLSS_CTRL_RST 1'h0

// Status word bit positions
`define HLSS_ST_BUSY 0
`define HLSS_ST_READY 1
`define HLSS_ST_FIRST 3
`define HLSS_ST_ATTN 7
`define HLSS_ST_SKCHK 8
// Clear-status control bus selects
`define HLSS_CLS_ATTN 0
`define HLSS_CLS_FIRST 1

`endif

/* design/hlss_sequencer.v */
// Head load, unload and seek start sequencer with AHB-Lite registers.
// Assumes servo, tag and control bus pins are asynchronous to hclk;
// the analog loop is outside and reports through digital inputs.
`timescale 1ns/1ps
`include "hlss_defs.vh"
`default_nettype none

module hlss_sequencer #(
  parameter integer SETTLE_CYC = `HLSS_SETTLE_CYC,
  parameter integer LOAD_TMO   = `HLSS_LOAD_TMO_CYC,
  parameter integer SEEK_TMO   = `HLSS_SEEK_TMO_CYC,
  parameter integer CYL_W      = 10,
  parameter integer TMR_W      = 24
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  input  wire              pack_present,
  input  wire              door_locked,
  input  wire              spindle_at_speed,
  input  wire              spindle_stopped,
  input  wire              gain_detect,
  input  wire              track_center_hit,
  input  wire              fine_position,
  input  wire              carriage_home_limit,
  input  wire              gain_raw,
  input  wire              carriage_back_raw,
  input  wire              interlock_fault,
  input  wire              destructive_write_fault,
  input  wire              phase_ref,
  input  wire              tag_seek,
  input  wire              tag_clear_status,
  input  wire              illegal_address_flag,
  input  wire [CYL_W-1:0]  control_bus,
  output reg  [8:0]        status_word,
  output reg               drive_ready_flag,
  output reg               access_ready_n,
  output reg               settle_brake_n,
  output reg               seek_home,
  output reg               servo_loop_enable,
  output reg               carriage_latch,
  output reg               reverse_slew,
  output reg               head_unload_request,
  output reg               spindle_run_latch,
  output reg               door_unlock,
  output reg               fault_detect_en,
  output reg               cmd_enable,
  output reg               first_clock_inhibit,
  output reg               servo_phase_select,
  output reg               peak_gate,
  output reg               seek_check_clear,
  output reg               offset_clear_n,
  output reg  [CYL_W-1:0]  new_cylinder
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_LOAD   = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_READY  = 3'h3;
  localparam [2:0] ST_SEEK   = 3'h4;
  localparam [2:0] ST_UNLOAD = 3'h5;
  localparam integer NSYNC   = 16 + CYL_W;

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  assign raw_in = {control_bus, illegal_address_flag, tag_clear_status,
                   tag_seek, phase_ref, destructive_write_fault,
                   interlock_fault, carriage_back_raw, gain_raw,
                   carriage_home_limit, fine_position, track_center_hit,
                   gain_detect, spindle_stopped, spindle_at_speed,
                   door_locked, pack_present};

  // Two flops per bit; only the second stage is ever read
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire             s_pack   = sync2_q[0];
  wire             s_door   = sync2_q[1];
  wire             s_speed  = sync2_q[2];
  wire             s_stpd   = sync2_q[3];
  wire             s_gain   = sync2_q[4];
  wire             s_tch    = sync2_q[5];
  wire             s_fine   = sync2_q[6];
  wire             s_home   = sync2_q[7];
  wire             s_graw   = sync2_q[8];
  wire             s_cbraw  = sync2_q[9];
  wire             s_ilf    = sync2_q[10];
  wire             s_dwf    = sync2_q[11];
  wire             s_ref    = sync2_q[12];
  wire             s_tseek  = sync2_q[13];
  wire             s_tcls   = sync2_q[14];
  wire             s_ica    = sync2_q[15];
  wire [CYL_W-1:0] s_cbus   = sync2_q[NSYNC-1:16];

  // Previous samples for edge detection
  reg gain_d_q;
  reg tch_d_q;
  reg tseek_d_q;
  reg tcls_d_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_d_q  <= 1'b0;
      tch_d_q   <= 1'b0;
      tseek_d_q <= 1'b0;
      tcls_d_q  <= 1'b0;
    end else begin
      gain_d_q  <= s_gain;
      tch_d_q   <= s_tch;
      tseek_d_q <= s_tseek;
      tcls_d_q  <= s_tcls;
    end
  end
  wire gain_rise = s_gain & ~gain_d_q;
  wire tch_rise  = s_tch & ~tch_d_q;
  wire cls_cmd   = s_tcls & ~tcls_d_q;

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  reg        run_req_q;
  reg        fclr_q;
  reg        wr_pend_q;
  reg  [3:0] wr_addr_q;
  reg  [2:0] state_q;
  wire       ahb_go = hsel & htrans[1] & hready;
  wire [3:0] a_off  = haddr[3:0];
  // Only the low 16 bytes are mapped; anything above reads zero
  wire       a_hit  = (haddr[31:4] == 28'h0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
      run_req_q <= `HLSS_CTRL_RST;
      fclr_q    <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      fclr_q    <= 1'b0;
      wr_pend_q <= ahb_go & hwrite & a_hit;
      if (ahb_go)
        wr_addr_q <= a_off;
      // Read data prepared at the address phase so it comes from a flop
      if (ahb_go & ~hwrite) begin
        case (a_hit ? a_off : 4'hf)
          `HLSS_REG_CTRL:   hrdata <= {31'h0, run_req_q};
          `HLSS_REG_STATUS: hrdata <= {20'h0, state_q, status_word};
          `HLSS_REG_CYL:    hrdata <= {{(32-CYL_W){1'b0}}, new_cylinder};
          default:          hrdata <= 32'h0;
        endcase
      end
      // Write data lands in the data phase
      if (wr_pend_q && wr_addr_q == `HLSS_REG_CTRL) begin
        run_req_q <= hwdata[`HLSS_CTRL_RUN];
        fclr_q    <= hwdata[`HLSS_CTRL_FCLR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Faults and unload request
  reg  gain_fault_q;
  reg  cback_fault_q;
  reg  timeout_fault_q;
  reg  tmr_run_q;
  reg  [TMR_W-1:0] tmr_q;
  wire stop      = ~run_req_q;
  wire tmr_exp   = tmr_run_q && (tmr_q == {TMR_W{1'b0}});
  wire unload_c  = stop | gain_fault_q | cback_fault_q | s_ilf | s_dwf |
                   timeout_fault_q | ~s_speed;

  // Detector faults are sticky; a new fault beats a clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_fault_q    <= 1'b0;
      cback_fault_q   <= 1'b0;
      timeout_fault_q <= 1'b0;
    end else begin
      if (fault_detect_en & s_graw)
        gain_fault_q <= 1'b1;
      else if (fclr_q)
        gain_fault_q <= 1'b0;
      if (fault_detect_en & s_cbraw)
        cback_fault_q <= 1'b1;
      else if (fclr_q)
        cback_fault_q <= 1'b0;
      if (tmr_exp)
        timeout_fault_q <= 1'b1;
      else if (fclr_q)
        timeout_fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  reg  [13:0] settle_q;
  reg         access_ready_attn_q;
  reg         ret_attn_q;
  reg         attn_hold_q;
  reg         first_q;
  reg         skchk_q;
  reg         access_ready_d_q;
  wire        seek_ok = s_tseek & ~tseek_d_q & ~access_ready_n &
                        ~settle_brake_n & cmd_enable;
  wire        load_ok = s_pack & s_door & s_speed & ~unload_c;
  wire        at_ctr  = s_tch & s_fine & ~seek_home;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q             <= ST_IDLE;
      tmr_q               <= {TMR_W{1'b0}};
      tmr_run_q           <= 1'b0;
      settle_q            <= 14'h0;
      drive_ready_flag    <= 1'b0;
      access_ready_n      <= 1'b1;
      settle_brake_n      <= 1'b1;
      seek_home           <= 1'b0;
      servo_loop_enable   <= 1'b0;
      carriage_latch      <= 1'b0;
      reverse_slew        <= 1'b0;
      head_unload_request <= 1'b0;
      spindle_run_latch   <= 1'b0;
      door_unlock         <= 1'b0;
      fault_detect_en     <= 1'b0;
      cmd_enable          <= 1'b0;
      first_clock_inhibit <= 1'b0;
      seek_check_clear    <= 1'b0;
      offset_clear_n      <= 1'b1;
      new_cylinder        <= {CYL_W{1'b0}};
    end else begin
      seek_check_clear    <= 1'b0;
      offset_clear_n      <= 1'b1;
      head_unload_request <= unload_c;
      if (tmr_run_q && !tmr_exp)
        tmr_q <= tmr_q - 1'b1;
      if (tmr_exp)
        tmr_run_q <= 1'b0;
      // Spindle runs on request with a pack in and the door locked
      if (run_req_q & s_pack & s_door)
        spindle_run_latch <= 1'b1;
      else if (s_home & stop)
        spindle_run_latch <= 1'b0;
      // Door waits for the brake to stop the spindle
      door_unlock <= stop & ~spindle_run_latch & s_stpd;
      if (state_q != ST_IDLE && state_q != ST_UNLOAD && unload_c) begin
        state_q          <= ST_UNLOAD;
        drive_ready_flag <= 1'b0;
        seek_home        <= 1'b0;
        carriage_latch   <= 1'b0;
        reverse_slew     <= 1'b1;
        tmr_q            <= LOAD_TMO[TMR_W-1:0];
        tmr_run_q        <= 1'b1;
        fault_detect_en  <= 1'b0;
        access_ready_n   <= 1'b1;
        settle_brake_n   <= 1'b1;
        cmd_enable       <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (load_ok && s_home) begin
              state_q           <= ST_LOAD;
              seek_home         <= 1'b1;
              servo_loop_enable <= 1'b1;
              carriage_latch    <= 1'b1;
              reverse_slew      <= 1'b0;
              tmr_q             <= LOAD_TMO[TMR_W-1:0];
              tmr_run_q         <= 1'b1;
              new_cylinder      <= {CYL_W{1'b0}};
              seek_check_clear  <= 1'b1;
              offset_clear_n    <= 1'b0;
            end
          end
          ST_LOAD: begin
            // Forward slew ends at the outer guard band edge
            if (gain_rise)
              seek_home <= 1'b0;
            if (at_ctr) begin
              settle_brake_n <= 1'b0;
              settle_q       <= SETTLE_CYC[13:0];
              state_q        <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            // Heads drift off center: release brake and keep hunting
            if (!at_ctr) begin
              settle_brake_n <= 1'b1;
              state_q        <= drive_ready_flag ? ST_SEEK : ST_LOAD;
            end else if (settle_q > 14'h1) begin
              settle_q <= settle_q - 14'h1;
            end else begin
              state_q          <= ST_READY;
              drive_ready_flag <= 1'b1;
              fault_detect_en  <= 1'b1;
              access_ready_n   <= 1'b0;
              tmr_run_q        <= 1'b0;
              cmd_enable       <= 1'b1;
            end
          end
          ST_READY: begin
            // Heads stay here until a seek or an unload
            if (seek_ok) begin
              state_q             <= ST_SEEK;
              tmr_q               <= SEEK_TMO[TMR_W-1:0];
              tmr_run_q           <= 1'b1;
              first_clock_inhibit <= 1'b1;
              if (!s_ica)
                new_cylinder <= s_cbus;
              seek_check_clear    <= 1'b1;
              offset_clear_n      <= 1'b0;
              access_ready_n      <= 1'b1;
              settle_brake_n      <= 1'b1;
              cmd_enable          <= 1'b0;
            end
          end
          ST_SEEK: begin
            if (tch_rise)
              first_clock_inhibit <= 1'b0;
            if (at_ctr && !first_clock_inhibit) begin
              settle_brake_n <= 1'b0;
              settle_q       <= SETTLE_CYC[13:0];
              state_q        <= ST_SETTLE;
            end
          end
          ST_UNLOAD: begin
            if (s_home) begin
              tmr_run_q         <= 1'b0;
              servo_loop_enable <= 1'b0;
              reverse_slew      <= 1'b0;
              state_q           <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Attention, first status and seek check flags; set beats clear
  wire access_ready_rise = ~access_ready_n & access_ready_d_q;
  wire access_ready_fall = access_ready_n & ~access_ready_d_q;
  wire ready_clr = (state_q != ST_IDLE) && (state_q != ST_UNLOAD) &&
                   unload_c && drive_ready_flag;
  wire attn_clr  = cls_cmd & s_cbus[`HLSS_CLS_ATTN];
  wire first_clr = cls_cmd & s_cbus[`HLSS_CLS_FIRST];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      access_ready_d_q    <= 1'b1;
      access_ready_attn_q <= 1'b0;
      ret_attn_q  <= 1'b0;
      attn_hold_q <= 1'b0;
      first_q     <= 1'b0;
      skchk_q     <= 1'b0;
    end else begin
      access_ready_d_q <= access_ready_n;
      // Unload keeps the attentions; a seek start lets them go
      if (access_ready_fall)
        attn_hold_q <= ~cmd_enable | head_unload_request | unload_c;
      else if (access_ready_rise)
        attn_hold_q <= 1'b0;
      if (access_ready_rise)
        access_ready_attn_q <= 1'b1;
      else if (attn_clr || (access_ready_fall && state_q == ST_SEEK))
        access_ready_attn_q <= 1'b0;
      if (ready_clr)
        ret_attn_q <= 1'b1;
      else if (attn_clr || (access_ready_fall && !attn_hold_q && state_q == ST_SEEK))
        ret_attn_q <= 1'b0;
      if (drive_ready_flag && state_q == ST_SETTLE && !access_ready_n)
        first_q <= 1'b1;
      else if (state_q == ST_SETTLE && settle_q == 14'h1 && at_ctr &&
               !drive_ready_flag)
        first_q <= 1'b1;
      else if (first_clr)
        first_q <= 1'b0;
      if (state_q == ST_SEEK && tmr_exp)
        skchk_q <= 1'b1;
      else if (seek_check_clear)
        skchk_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word, phase select and peak gating, all from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_word        <= 9'h0;
      servo_phase_select <= 1'b0;
      peak_gate          <= 1'b0;
    end else begin
      status_word                <= 9'h0;
      status_word[`HLSS_ST_BUSY]  <= access_ready_n;
      status_word[`HLSS_ST_READY] <= drive_ready_flag;
      status_word[`HLSS_ST_FIRST] <= first_q;
      status_word[`HLSS_ST_ATTN]  <= access_ready_attn_q | ret_attn_q;
      status_word[`HLSS_ST_SKCHK] <= skchk_q;
      servo_phase_select <= new_cylinder[0];
      peak_gate          <= s_ref ^ new_cylinder[0];
    end
  end

endmodule // hlss_sequencer

`default_nettype wire

/* sim/hlss_ctrl_model.sv */
// Disc controller model: tag bus commands with data on the control bus.
// Assumes the sequencer syncs tags in two flops and takes them on a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hlss_ctrl_model (
  input  wire logic       hclk,
  output var  logic       tag_seek,
  output var  logic       tag_clear_status,
  output var  logic       illegal_address_flag,
  output var  logic [9:0] control_bus
);
  // Lines idle low at time zero
  initial begin
    tag_seek = 1'b0;
    tag_clear_status = 1'b0;
    illegal_address_flag = 1'b0;
    control_bus = 10'h0;
  end
  // One command; data stands for the whole tag window
  task cmd(input logic sk, input logic [9:0] d, input logic ill);
    @(posedge hclk);
    control_bus <= d;
    illegal_address_flag <= ill;
    tag_seek <= sk;
    tag_clear_status <= ~sk;
    // Four edges outlast the sync delay and the taking edge
    repeat (4) @(posedge hclk);
    tag_seek <= 1'b0;
    tag_clear_status <= 1'b0;
    // Released lines carry garbage, so stale data is never read as valid
    control_bus <= ~d;
    illegal_address_flag <= ~ill;
    repeat (4) @(posedge hclk);
  endtask
endmodule // hlss_ctrl_model
`default_nettype wire

/* sim/hlss_seq_monitor.sv */
// Concurrent checks on the head load and seek sequencer's top ports.
// Assumes one clock, hclk, and an asynchronous active-low hresetn.
`timescale 1ns/1ps
`default_nettype none
module hlss_seq_monitor #(
  parameter integer SETTLE_CYC = 20
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [8:0] status_word,
  input wire logic [9:0] new_cylinder,
  input wire logic       drive_ready_flag,
  input wire logic       access_ready_n,
  input wire logic       settle_brake_n,
  input wire logic       seek_home,
  input wire logic       servo_loop_enable,
  input wire logic       reverse_slew,
  input wire logic       head_unload_request,
  input wire logic       spindle_run_latch,
  input wire logic       door_unlock,
  input wire logic       fault_detect_en,
  input wire logic       first_clock_inhibit,
  input wire logic       servo_phase_select,
  input wire logic       peak_gate,
  input wire logic       seek_check_clear,
  input wire logic       offset_clear_n,
  input wire logic       phase_ref,
  input wire logic       track_center_hit,
  input wire logic       fine_position,
  input wire logic       carriage_home_limit,
  input wire logic       spindle_stopped
);
  logic [15:0] brk_cnt_q;
  logic [15:0] brk_cnt_d;
  // Brake-low age; a counter since the settle time is too long for a repetition
  assign brk_cnt_d = settle_brake_n ? 16'h0 : brk_cnt_q + 16'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) brk_cnt_q <= 16'h0;
    else brk_cnt_q <= brk_cnt_d;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Servo phase and peak gating follow the cylinder LSB
  chk_phase_lsb: assert property (
    !$stable(new_cylinder) |-> ##[0:1] servo_phase_select == new_cylinder[0])
    else $error("phase select differs from cylinder lsb");
  chk_peak_xor: assert property (
    ($stable(phase_ref) && $stable(new_cylinder))[*4] |->
      peak_gate == (phase_ref ^ new_cylinder[0]))
    else $error("peak gate is not reference xor lsb");
  chk_brake_center: assert property (
    $fell(settle_brake_n) |-> track_center_hit && fine_position)
    else $error("brake set away from track center");
  // Ready may only come one settle time after the brake
  chk_ready_settle: assert property (
    $rose(drive_ready_flag) |-> brk_cnt_q + 16'd2 >= SETTLE_CYC && brk_cnt_q <= SETTLE_CYC + 2)
    else $error("drive ready outside settle delay");
  chk_ready_status: assert property (
    $rose(drive_ready_flag) |-> ##[0:2]
      (status_word[1] && status_word[3] && fault_detect_en && !access_ready_n))
    else $error("ready side effects missing");
  chk_busy_bit: assert property (
    !$stable(access_ready_n) |-> ##[0:1] status_word[0] == access_ready_n)
    else $error("busy bit does not track access ready");
  chk_unload_clear: assert property (
    $rose(head_unload_request) && $past(drive_ready_flag) |-> ##[0:2]
      (!drive_ready_flag && reverse_slew && access_ready_n && !seek_home && status_word[7]))
    else $error("unload side effects missing");
  chk_home_servo: assert property (
    head_unload_request && $rose(carriage_home_limit) |-> ##[1:4] !servo_loop_enable)
    else $error("servo still enabled at home");
  chk_door_stop: assert property (
    $rose(door_unlock) |-> spindle_stopped && !spindle_run_latch)
    else $error("door unlocked before spindle stop");
  chk_seek_gate: assert property (
    $rose(first_clock_inhibit) |->
      $past(access_ready_n) == 1'b0 && $past(settle_brake_n) == 1'b0 && seek_check_clear)
    else $error("seek accepted while not settled");
  chk_seek_pulse: assert property (
    $rose(seek_check_clear) |-> !offset_clear_n ##1
      (!seek_check_clear && offset_clear_n) ##1 !status_word[8])
    else $error("seek clear pulses wrong");
endmodule // hlss_seq_monitor
bind hlss_sequencer hlss_seq_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_mon (
  .hclk, .hresetn, .status_word, .new_cylinder, .drive_ready_flag, .access_ready_n,
  .settle_brake_n, .seek_home, .servo_loop_enable, .reverse_slew, .head_unload_request,
  .spindle_run_latch, .door_unlock, .fault_detect_en, .first_clock_inhibit,
  .servo_phase_select, .peak_gate, .seek_check_clear, .offset_clear_n, .phase_ref,
  .track_center_hit, .fine_position, .carriage_home_limit, .spindle_stopped);
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the head load and seek sequencer.
// Assumes a 10 MHz hclk, AHB-Lite registers and the controller model on the tag bus.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
  logic        pack_present = 1'b0, door_locked = 1'b0, spindle_at_speed = 1'b0;
  logic        spindle_stopped = 1'b0, gain_detect = 1'b0, track_center_hit = 1'b0;
  logic        fine_position = 1'b0, carriage_home_limit = 1'b0, phase_ref = 1'b0;
  logic        gain_raw = 1'b0, carriage_back_raw = 1'b0;
  logic        interlock_fault = 1'b0, destructive_write_fault = 1'b0;
  wire logic [31:0] hrdata;
  wire logic [9:0]  control_bus, new_cylinder;
  wire logic [8:0]  status_word;
  wire logic        hreadyout, hresp, tag_seek, tag_clear_status, illegal_address_flag;
  wire logic        drive_ready_flag, access_ready_n, settle_brake_n, seek_home;
  wire logic        servo_loop_enable, carriage_latch, reverse_slew, head_unload_request;
  wire logic        spindle_run_latch, door_unlock, fault_detect_en, cmd_enable;
  wire logic        first_clock_inhibit, servo_phase_select, peak_gate;
  wire logic        seek_check_clear, offset_clear_n;
  wire logic [8:0]  obs = {first_clock_inhibit, door_unlock, spindle_run_latch,
    servo_loop_enable, drive_ready_flag, seek_home, settle_brake_n, access_ready_n,
    head_unload_request};
  int error_cnt = 0;
  int compares = 0;
  // Short counts keep the run brief
  hlss_sequencer #(.SETTLE_CYC(20), .LOAD_TMO(400), .SEEK_TMO(200)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pack_present, .door_locked,
    .spindle_at_speed, .spindle_stopped, .gain_detect, .track_center_hit, .fine_position,
    .carriage_home_limit, .gain_raw, .carriage_back_raw, .interlock_fault,
    .destructive_write_fault, .phase_ref, .tag_seek, .tag_clear_status,
    .illegal_address_flag, .control_bus, .status_word, .drive_ready_flag,
    .access_ready_n, .settle_brake_n, .seek_home, .servo_loop_enable, .carriage_latch,
    .reverse_slew, .head_unload_request, .spindle_run_latch, .door_unlock,
    .fault_detect_en, .cmd_enable, .first_clock_inhibit, .servo_phase_select,
    .peak_gate, .seek_check_clear, .offset_clear_n, .new_cylinder);
  hlss_ctrl_model m (.hclk, .tag_seek, .tag_clear_status, .illegal_address_flag,
    .control_bus);
  ////////////////////////////////////////////////////////////////////////////////
  always #50 hclk = ~hclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; read data lands in rdat
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  // Bounded wait for one observed output to reach a level
  task wt(input int i, input logic v);
    int n;
    n = 0;
    while (obs[i] !== v && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    chk(obs[i], v);
  endtask
  // Track center drops and returns, as when the heads cross onto the target
  task land;
    track_center_hit <= 1'b0;
    repeat (4) @(posedge hclk);
    track_center_hit <= 1'b1;
    wt(8, 1'b0);
    wt(1, 1'b0);
  endtask
  task results;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (8000) @(posedge hclk);
    error_cnt++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({access_ready_n, settle_brake_n, offset_clear_n, drive_ready_flag}, 4'he);
    pack_present <= 1'b1;
    door_locked <= 1'b1;
    spindle_at_speed <= 1'b1;
    carriage_home_limit <= 1'b1;
    ahb(1'b1, 32'h0, 32'h1);
    wt(3, 1'b1);
    chk(servo_loop_enable, 1'b1);
    chk({hresp, carriage_latch}, 2'h1);
    chk(servo_phase_select, 1'b0);
    carriage_home_limit <= 1'b0;
    gain_detect <= 1'b1;
    wt(3, 1'b0);
    fine_position <= 1'b1;
    track_center_hit <= 1'b1;
    wt(2, 1'b0);
    wt(4, 1'b1);
    wt(1, 1'b0);
    chk(cmd_enable, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rdat[8:0], 9'h08a);
    m.cmd(1'b0, 10'h002, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rdat[8:0], 9'h082);
    m.cmd(1'b0, 10'h001, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rdat[8:0], 9'h002);
    chk(access_ready_n, 1'b0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rdat, 32'h0);
    phase_ref <= 1'b1;
    m.cmd(1'b1, 10'h2a5, 1'b0);
    wt(1, 1'b1);
    chk(new_cylinder, 10'h2a5);
    chk(servo_phase_select, 1'b1);
    land;
    chk(peak_gate, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rdat[8:0], 9'h082);
    phase_ref <= 1'b0;
    m.cmd(1'b1, 10'h0f0, 1'b1);
    wt(1, 1'b1);
    chk(new_cylinder, 10'h2a5);
    land;
    ahb(1'b1, 32'h0, 32'h0);
    wt(0, 1'b1);
    wt(4, 1'b0);
    chk(reverse_slew, 1'b1);
    chk(carriage_latch, 1'b0);
    chk(cmd_enable, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rdat[8:0], 9'h081);
    carriage_home_limit <= 1'b1;
    wt(5, 1'b0);
    wt(6, 1'b0);
    chk(door_unlock, 1'b0);
    spindle_at_speed <= 1'b0;
    spindle_stopped <= 1'b1;
    wt(7, 1'b1);
    // Reload with no guard band edge: the load timer must run out and unload
    spindle_at_speed <= 1'b1;
    spindle_stopped <= 1'b0;
    ahb(1'b1, 32'h0, 32'h1);
    wt(3, 1'b1);
    wt(0, 1'b1);
    chk(servo_loop_enable, 1'b1);
    wt(5, 1'b0);
    results;
  end
endmodule // tb_top
`default_nettype wire
